// ### design/spi_status_idle_control_pkg.sv
// Purpose: shared constants, types and decode for the serial port status/control block
// Assumes: AHB-Lite register access, one 32-bit word per register
// Notes:   printed offsets are word indices; the byte address is four times the index
package spi_status_idle_control_pkg;

    // register indices, byte address = index * 4
    localparam logic [9:0] IDX_STAT1    = 10'h220;
    localparam logic [9:0] IDX_CON1     = 10'h222;
    localparam logic [9:0] IDX_BUF1     = 10'h224;
    localparam logic [9:0] IDX_STAT2    = 10'h226;
    localparam logic [9:0] IDX_CON2     = 10'h228;
    localparam logic [9:0] IDX_BUF2     = 10'h22A;
    localparam logic [9:0] IDX_IRQ_STAT = 10'h22C;
    localparam logic [9:0] IDX_IRQ_MASK = 10'h22E;

    // status register fields
    localparam int STAT_EN_BIT   = 15;
    localparam int STAT_SIDL_BIT = 13;
    localparam int STAT_OVF_BIT  = 6;
    localparam int STAT_FULL_BIT = 0;
    localparam logic [15:0] STAT_UNIMPL_MASK = 16'h5FBE;

    // control register fields
    localparam int CON_DISSDO_BIT = 11;
    localparam int CON_MODE16_BIT = 10;
    localparam int CON_CKE_BIT    = 8;
    localparam int CON_SSEN_BIT   = 7;
    localparam int CON_CKP_BIT    = 6;
    localparam logic [15:0] CON_WR_MASK = 16'h6FFF;

    // values after reset
    localparam logic [15:0] CON_RESET = 16'h0000;
    localparam logic [15:0] BUF_RESET = 16'h0000;
    localparam logic [3:0]  IRQ_RESET = 4'h0;

    // interrupt bits: port p uses bit 2p for receive done, 2p+1 for overflow
    localparam int IRQ_W = 4;

    // bit counts per transfer, as last index
    localparam logic [3:0] BYTE_LAST = 4'h7;
    localparam logic [3:0] WORD_LAST = 4'hF;

    localparam int SYNC_W = 6;

    typedef struct packed {
        logic run;
        logic mode16;
        logic ssen;
        logic ckp;
        logic cke;
        logic dis_sdo;
    } eng_ctrl_t;

    typedef struct packed {
        logic        done;
        logic [15:0] data;
    } eng_evt_t;

    typedef enum {SEL_NONE, SEL_STAT, SEL_CON, SEL_BUF, SEL_IRQ_STAT, SEL_IRQ_MASK} reg_sel_t;

    typedef struct packed {
        reg_sel_t sel;
        logic     port;
    } reg_dec_t;

    function automatic reg_dec_t reg_decode(input logic [31:0] a);
        reg_dec_t d;
        d.sel  = SEL_NONE;
        d.port = 1'b0;
        if (a[31:12] == 20'h00000 && a[1:0] == 2'h0) begin
            case (a[11:2])
                IDX_STAT1:    d.sel = SEL_STAT;
                IDX_CON1:     d.sel = SEL_CON;
                IDX_BUF1:     d.sel = SEL_BUF;
                IDX_STAT2:    begin d.sel = SEL_STAT; d.port = 1'b1; end
                IDX_CON2:     begin d.sel = SEL_CON;  d.port = 1'b1; end
                IDX_BUF2:     begin d.sel = SEL_BUF;  d.port = 1'b1; end
                IDX_IRQ_STAT: d.sel = SEL_IRQ_STAT;
                IDX_IRQ_MASK: d.sel = SEL_IRQ_MASK;
                default:      d.sel = SEL_NONE;
            endcase
        end
        return d;
    endfunction

endpackage

// ### design/pin_sync3.sv
// Purpose: three-flop synchroniser for pin inputs
// Assumes: inputs asynchronous to clock_i
// Notes:   output follows only once the second and third stages agree
`timescale 1ns/1ns
module pin_sync3
    import spi_status_idle_control_pkg::*;
#(
    parameter int W = SYNC_W
) (
    // clock and reset
    input  wire logic         clock_i,
    input  wire logic         rstn_i,
    // pins
    input  wire logic [W-1:0] pin_i,
    output logic      [W-1:0] level_o
);
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
        logic [W-1:0] s3;
        logic [W-1:0] lvl;
    } sync_state_t;

    sync_state_t s_ff;
    sync_state_t nxt_s;

    always_comb begin
        nxt_s    = s_ff;
        nxt_s.s1 = pin_i;
        nxt_s.s2 = s_ff.s1;
        nxt_s.s3 = s_ff.s2;
        for (int i = 0; i < W; i++) begin
            if (s_ff.s2[i] == s_ff.s3[i]) begin
                nxt_s.lvl[i] = s_ff.s3[i];
            end
        end
    end

    always_ff @(posedge clock_i) begin
        if (!rstn_i) begin
            s_ff <= '0;
        end else begin
            s_ff <= nxt_s;
        end
    end

    assign level_o = s_ff.lvl;
endmodule // pin_sync3

// ### design/shift_engine.sv
// Purpose: slave-mode shift register for one serial port
// Assumes: serial clock, data-in and select are already synchronised
// Notes:   any stop of run, a select release while ssen is set or a width change restarts at the first bit
`timescale 1ns/1ns
module shift_engine
    import spi_status_idle_control_pkg::*;
(
    // clock and reset
    input  wire logic        clock_i,
    input  wire logic        rstn_i,
    // control and data from the register side
    input  wire eng_ctrl_t   ctrl_i,
    input  wire logic [15:0] tx_data_i,
    output eng_evt_t         evt_o,
    // synchronised pins
    input  wire logic        sck_i,
    input  wire logic        sdi_i,
    input  wire logic        ss_i,
    output logic             sdo_o,
    output logic             sdo_oe_o
);
    typedef struct packed {
        logic        lvl_prev;
        logic        mode_prev;
        logic [3:0]  cnt;
        logic [15:0] shreg;
        logic        sdo;
        eng_evt_t    evt;
    } eng_state_t;

    eng_state_t s_ff;
    eng_state_t nxt_s;
    logic       lvl;
    logic       rise;
    logic       fall;
    logic       samp;
    logic       shft;
    logic       idle_sel;

    always_comb begin
        nxt_s     = s_ff;
        lvl       = sck_i ^ ctrl_i.ckp;
        rise      = lvl & ~s_ff.lvl_prev;
        fall      = ~lvl & s_ff.lvl_prev;
        samp      = ctrl_i.cke ? rise : fall;
        shft      = ctrl_i.cke ? fall : rise;
        idle_sel  = ctrl_i.ssen & ss_i;
        nxt_s.lvl_prev  = lvl;
        nxt_s.mode_prev = ctrl_i.mode16;
        nxt_s.evt.done  = 1'b0;
        if (!ctrl_i.run || idle_sel || ctrl_i.mode16 != s_ff.mode_prev) begin
            // a halted port drops its partial word
            nxt_s.cnt   = 4'h0;
            nxt_s.shreg = tx_data_i;
            // first bit must already stand when the first edge is a sample edge
            nxt_s.sdo   = ctrl_i.mode16 ? tx_data_i[15] : tx_data_i[7];
        end else if (samp) begin
            nxt_s.shreg = {s_ff.shreg[14:0], sdi_i};
            nxt_s.cnt   = s_ff.cnt + 4'h1;
            if (s_ff.cnt == (ctrl_i.mode16 ? WORD_LAST : BYTE_LAST)) begin
                nxt_s.evt.done = 1'b1;
                nxt_s.evt.data = ctrl_i.mode16 ? {s_ff.shreg[14:0], sdi_i}
                                               : {8'h00, s_ff.shreg[6:0], sdi_i};
                nxt_s.cnt      = 4'h0;
                nxt_s.shreg    = tx_data_i;
            end
        end else if (shft) begin
            nxt_s.sdo = ctrl_i.mode16 ? s_ff.shreg[15] : s_ff.shreg[7];
        end
    end

    always_ff @(posedge clock_i) begin
        if (!rstn_i) begin
            s_ff <= '0;
        end else begin
            s_ff <= nxt_s;
        end
    end

    assign evt_o    = s_ff.evt;
    assign sdo_o    = s_ff.sdo;
    assign sdo_oe_o = ctrl_i.run & ~ctrl_i.dis_sdo & ~idle_sel;
endmodule // shift_engine

// ### design/spi_status_idle_control.sv
// Purpose: register file, status flags, idle/sleep gating and interrupt for two serial ports
// Assumes: AHB-Lite single word transfers, 20 MHz clock_i, slave-mode serial ports
// Notes:   reads take one wait state so a preceding write is always visible
//
// The implementer's own choice: register access over AHB-Lite.
`timescale 1ns/1ns

// Notes on behaviour
// - all clocks stay running during processor idle
// - idle-stop bit 13 halts port while idle
// - enable bit 15 gives pins to port
// - cleared enable releases pins, port stays still
// - overflow bit 6 set on unread completion
// - full bit 0 set on completed reception
// - buffer read or write clears full bit
// - unimplemented status bits always read zero
// - overflow blocks buffer load, halts port while buffer full
// - completed word copies into transfer buffer
// - sleep aborts transfer, registers keep contents
module spi_status_idle_control
    import spi_status_idle_control_pkg::*;
(
    // clock and reset
    input  wire logic              clock_i,
    input  wire logic              rstn_i,
    // AHB-Lite slave
    input  wire logic              hsel_i,
    input  wire logic [31:0]       haddr_i,
    input  wire logic [1:0]        htrans_i,
    input  wire logic              hwrite_i,
    input  wire logic [2:0]        hsize_i,
    input  wire logic [31:0]       hwdata_i,
    input  wire logic              hready_i,
    output logic      [31:0]       hrdata_o,
    output logic                   hreadyout_o,
    output logic                   hresp_o,
    // processor power state
    input  wire logic              cpu_idle_i,
    input  wire logic              cpu_sleep_i,
    // serial pins, one bit per port
    input  wire logic [1:0]        serial_clock_pin_i,
    input  wire logic [1:0]        data_in_pin_i,
    input  wire logic [1:0]        select_pin_i,
    output logic      [1:0]        data_out_pin_o,
    output logic      [1:0]        data_out_pin_oe_o,
    output logic      [1:0]        pin_func_o,
    // interrupt
    output logic                   irq_o
);
    typedef struct packed {
        logic [1:0]        en;
        logic [1:0]        sidl;
        logic [1:0]        ovf;
        logic [1:0]        full;
        logic [1:0][15:0]  con;
        logic [1:0][15:0]  rxbuf;
        logic [1:0][15:0]  txbuf;
        logic [IRQ_W-1:0]  irq_stat;
        logic [IRQ_W-1:0]  irq_mask;
        logic              dp_valid;
        logic              dp_write;
        reg_dec_t          dp_dec;
        logic              rd_done;
        logic [31:0]       hrdata;
    } top_state_t;

    top_state_t       s_ff;
    top_state_t       nxt_s;
    eng_ctrl_t [1:0]  ctrl;
    eng_evt_t  [1:0]  evt;
    logic [SYNC_W-1:0] pins_sync;
    logic             acc;
    logic             rd_pend;
    logic             wr_now;
    logic [15:0]      rd_val;
    logic             p;

    pin_sync3 #(.W(SYNC_W)) u_sync (
        .clock_i (clock_i),
        .rstn_i  (rstn_i),
        .pin_i   ({select_pin_i, data_in_pin_i, serial_clock_pin_i}),
        .level_o (pins_sync)
    );

    for (genvar g = 0; g < 2; g++) begin : g_port
        always_comb begin
            // idle and sleep only gate the port's logic; no clock is stopped
            ctrl[g].run     = s_ff.en[g] & ~cpu_sleep_i
                            & ~(cpu_idle_i & s_ff.sidl[g])
                            & ~(s_ff.ovf[g] & s_ff.full[g]);
            ctrl[g].mode16  = s_ff.con[g][CON_MODE16_BIT];
            ctrl[g].ssen    = s_ff.con[g][CON_SSEN_BIT];
            ctrl[g].ckp     = s_ff.con[g][CON_CKP_BIT];
            ctrl[g].cke     = s_ff.con[g][CON_CKE_BIT];
            ctrl[g].dis_sdo = s_ff.con[g][CON_DISSDO_BIT];
        end

        shift_engine u_eng (
            .clock_i   (clock_i),
            .rstn_i    (rstn_i),
            .ctrl_i    (ctrl[g]),
            .tx_data_i (s_ff.txbuf[g]),
            .evt_o     (evt[g]),
            .sck_i     (pins_sync[g]),
            .sdi_i     (pins_sync[2 + g]),
            .ss_i      (pins_sync[4 + g]),
            .sdo_o     (data_out_pin_o[g]),
            .sdo_oe_o  (data_out_pin_oe_o[g])
        );
    end

    always_comb begin
        nxt_s   = s_ff;
        acc     = hsel_i & htrans_i[1] & hready_i;
        rd_pend = s_ff.dp_valid & ~s_ff.dp_write & ~s_ff.rd_done;
        wr_now  = s_ff.dp_valid & s_ff.dp_write;
        p       = s_ff.dp_dec.port;
        rd_val  = 16'h0000;

        // read data phase: value is registered, side effects happen here
        case (s_ff.dp_dec.sel)
            SEL_STAT:     rd_val = {s_ff.en[p], 1'b0, s_ff.sidl[p], 6'h00,
                                    s_ff.ovf[p], 5'h00, s_ff.full[p]};
            SEL_CON:      rd_val = s_ff.con[p];
            SEL_BUF:      rd_val = s_ff.rxbuf[p];
            SEL_IRQ_STAT: rd_val = {12'h000, s_ff.irq_stat};
            SEL_IRQ_MASK: rd_val = {12'h000, s_ff.irq_mask};
            default:      rd_val = 16'h0000;
        endcase
        if (rd_pend) begin
            nxt_s.hrdata  = {16'h0000, rd_val};
            nxt_s.rd_done = 1'b1;
            if (s_ff.dp_dec.sel == SEL_BUF) begin
                nxt_s.full[p] = 1'b0;
            end
        end

        // write data phase, always zero wait
        if (wr_now) begin
            case (s_ff.dp_dec.sel)
                SEL_STAT: begin
                    nxt_s.en[p]   = hwdata_i[STAT_EN_BIT];
                    nxt_s.sidl[p] = hwdata_i[STAT_SIDL_BIT];
                    nxt_s.ovf[p]  = hwdata_i[STAT_OVF_BIT];
                end
                SEL_CON:      nxt_s.con[p] = hwdata_i[15:0] & CON_WR_MASK;
                SEL_BUF: begin
                    nxt_s.txbuf[p] = hwdata_i[15:0];
                    nxt_s.full[p]  = 1'b0;
                end
                SEL_IRQ_STAT: nxt_s.irq_stat = s_ff.irq_stat & ~hwdata_i[IRQ_W-1:0];
                SEL_IRQ_MASK: nxt_s.irq_mask = hwdata_i[IRQ_W-1:0];
                default:      nxt_s.hrdata = s_ff.hrdata;
            endcase
        end

        // completions after bus effects so a set in the same cycle wins
        for (int i = 0; i < 2; i++) begin
            if (evt[i].done) begin
                nxt_s.irq_stat[2*i] = 1'b1;
                if (!s_ff.full[i] && !s_ff.ovf[i]) begin
                    nxt_s.rxbuf[i] = evt[i].data;
                    nxt_s.full[i]  = 1'b1;
                end else begin
                    // the new word is dropped, the old one stays for software
                    nxt_s.ovf[i]          = 1'b1;
                    nxt_s.irq_stat[2*i+1] = 1'b1;
                end
            end
        end

        // address phase
        if (acc) begin
            nxt_s.dp_valid = 1'b1;
            nxt_s.dp_write = hwrite_i;
            nxt_s.dp_dec   = reg_decode(haddr_i);
            nxt_s.rd_done  = 1'b0;
        end else if (s_ff.dp_valid && hready_i) begin
            nxt_s.dp_valid = 1'b0;
        end
    end

    always_ff @(posedge clock_i) begin
        if (!rstn_i) begin
            s_ff.en       <= 2'h0;
            s_ff.sidl     <= 2'h0;
            s_ff.ovf      <= 2'h0;
            s_ff.full     <= 2'h0;
            s_ff.con      <= {CON_RESET, CON_RESET};
            s_ff.rxbuf    <= {BUF_RESET, BUF_RESET};
            s_ff.txbuf    <= {BUF_RESET, BUF_RESET};
            s_ff.irq_stat <= IRQ_RESET;
            s_ff.irq_mask <= IRQ_RESET;
            s_ff.dp_valid <= 1'b0;
            s_ff.dp_write <= 1'b0;
            s_ff.dp_dec   <= '{sel: SEL_NONE, port: 1'b0};
            s_ff.rd_done  <= 1'b0;
            s_ff.hrdata   <= 32'h00000000;
        end else begin
            s_ff <= nxt_s;
        end
    end

    // hsize is not decoded: only whole-word transfers are expected
    assign hrdata_o    = s_ff.hrdata;
    assign hreadyout_o = ~rd_pend;
    assign hresp_o     = 1'b0;
    assign pin_func_o  = s_ff.en;
    assign irq_o       = |(s_ff.irq_stat & s_ff.irq_mask);

    // ---------------- assertions ----------------
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!rstn_i);

    chk_stat_unimpl_zero: assert property (
        rd_pend && s_ff.dp_dec.sel == SEL_STAT
        |=> (hrdata_o[15:0] & STAT_UNIMPL_MASK) == 16'h0000 && hrdata_o[31:16] == 16'h0000)
        else $error("unimplemented status bits read nonzero");

    chk_full_on_rx: assert property (
        evt[0].done && !s_ff.full[0] && !s_ff.ovf[0] |=> s_ff.full[0])
        else $error("buffer full flag not set on reception");

    chk_rx_copy: assert property (
        evt[1].done && !s_ff.full[1] && !s_ff.ovf[1]
        |=> s_ff.rxbuf[1] == $past(evt[1].data))
        else $error("received word not copied to buffer");

    chk_ovf_on_full: assert property (
        evt[0].done && s_ff.full[0] |=> s_ff.ovf[0] && $stable(s_ff.rxbuf[0]))
        else $error("overflow not flagged or buffer overwritten");

    chk_ovf_halts: assert property (
        s_ff.ovf[0] && s_ff.full[0] |-> !ctrl[0].run ##1 !evt[0].done)
        else $error("port runs while overflow holds buffer");

    chk_full_clr_read: assert property (
        rd_pend && s_ff.dp_dec.sel == SEL_BUF && s_ff.dp_dec.port == 1'b0 && !evt[0].done
        |=> !s_ff.full[0])
        else $error("buffer read did not clear full flag");

    chk_disabled_pins: assert property (
        !s_ff.en[1] |-> !pin_func_o[1] && !data_out_pin_oe_o[1] && !ctrl[1].run)
        else $error("disabled port still owns pins");

    chk_idle_stop: assert property (
        cpu_idle_i && s_ff.sidl[0] |-> !ctrl[0].run)
        else $error("port runs in idle with idle-stop set");

    chk_idle_continue: assert property (
        cpu_idle_i && !cpu_sleep_i && s_ff.en[0] && !s_ff.sidl[0] && !s_ff.ovf[0]
        |-> ctrl[0].run)
        else $error("port stopped in idle with idle-stop clear");

    chk_sleep_keeps: assert property (
        cpu_sleep_i && !s_ff.dp_valid |-> !ctrl[0].run ##1 $stable(s_ff.con) && $stable(s_ff.en))
        else $error("sleep did not halt port or changed registers");

    chk_full_on_rx1: assert property (
        evt[1].done && !s_ff.full[1] && !s_ff.ovf[1] |=> s_ff.full[1])
        else $error("port 2 buffer full flag not set on reception");

    chk_rx_copy0: assert property (
        evt[0].done && !s_ff.full[0] && !s_ff.ovf[0]
        |=> s_ff.rxbuf[0] == $past(evt[0].data))
        else $error("port 1 received word not copied to buffer");

    chk_ovf_on_full1: assert property (
        evt[1].done && s_ff.full[1] |=> s_ff.ovf[1] && $stable(s_ff.rxbuf[1]))
        else $error("port 2 overflow not flagged or buffer overwritten");

    chk_ovf_halts1: assert property (
        s_ff.ovf[1] && s_ff.full[1] |-> !ctrl[1].run ##1 !evt[1].done)
        else $error("port 2 runs while overflow holds buffer");

    chk_full_clr_write: assert property (
        wr_now && s_ff.dp_dec.sel == SEL_BUF && s_ff.dp_dec.port == 1'b0 && !evt[0].done
        |=> !s_ff.full[0])
        else $error("buffer write did not clear full flag");

    chk_disabled_pins0: assert property (
        !s_ff.en[0] |-> !pin_func_o[0] && !data_out_pin_oe_o[0] && !ctrl[0].run)
        else $error("disabled port 1 still owns pins");

    chk_enabled_pins: assert property (
        s_ff.en[0] && !cpu_sleep_i && !cpu_idle_i && !s_ff.ovf[0]
        && !s_ff.con[0][CON_DISSDO_BIT] && !s_ff.con[0][CON_SSEN_BIT]
        |-> pin_func_o[0] && data_out_pin_oe_o[0])
        else $error("enabled port 1 does not own its pins");

    chk_idle_stop1: assert property (
        cpu_idle_i && s_ff.sidl[1] |-> !ctrl[1].run)
        else $error("port 2 runs in idle with idle-stop set");

    chk_sleep_halts1: assert property (
        cpu_sleep_i |-> !ctrl[1].run && !data_out_pin_oe_o[1])
        else $error("port 2 runs during sleep");

    chk_read_one_wait: assert property (
        rd_pend |=> !rd_pend && hreadyout_o)
        else $error("read data phase held more than one wait state");

    cov_overflow:  cover property (evt[0].done && s_ff.full[0]);
    cov_buf_read:  cover property (rd_pend && s_ff.dp_dec.sel == SEL_BUF && s_ff.full[0]);
    cov_idle_stop: cover property (cpu_idle_i && s_ff.sidl[1] && s_ff.en[1]);
    cov_irq:       cover property ($rose(irq_o));
    cov_sleep:     cover property (cpu_sleep_i && s_ff.en[0]);
endmodule // spi_status_idle_control

// ### tb/spi_master_model.sv
// Purpose: behavioural serial controller that clocks one slave port of the block
// Assumes: clock polarity idle low, slave samples on the rising serial clock (CKE=1)
// Notes:   serial clock stands still between frames; released data line shows the inverse value
`timescale 1ns/1ns
module spi_master_model (
    // serial pins towards the block
    output logic        sck_o,
    output logic        sdi_o,
    output logic        ss_n_o,
    // serial data back from the block
    input  wire logic   sdo_i,
    output logic [15:0] got_o
);
    initial begin
        got_o  = 16'h0000;
        sck_o  = 1'b0;
        sdi_o  = 1'b0;
        ss_n_o = 1'b1;
    end

    // half period of 200 ns, the offset keeps the link out of phase with clock_i
    task automatic xfer(input logic [15:0] d, input int n);
        #37 ss_n_o = 1'b0;
        for (int i = n - 1; i >= 0; i--) begin
            sdi_o = d[i];
            #200 sck_o = 1'b1;
            // the slave moves its output some clocks after the falling edge,
            // so take it at the very end of the active half
            #199 got_o = {got_o[14:0], sdo_i};
            #1 sck_o = 1'b0;
        end
        // line released: no pull, so show the opposite of the last bit
        sdi_o = ~sdi_o;
        #400 ss_n_o = 1'b1;
    endtask
endmodule // spi_master_model

// ### tb/spi_status_idle_control_tb.sv
// Purpose: self-checking bench for status flags, idle/sleep gating and interrupt of two ports
// Assumes: one AHB-Lite slave, its hreadyout fed back as hready
// Notes:   received values are random from a fixed seed; ports run slave mode, 8 and 16 bit
`timescale 1ns/1ns
module spi_status_idle_control_tb;
    import spi_status_idle_control_pkg::*;

    logic        clock_i, rstn_i, hsel, hwrite, cpu_idle, cpu_sleep, irq, hready, hresp, p2;
    logic [1:0]  htrans, sdo, sdo_oe, pin_func;
    logic [31:0] haddr, hwdata, hrdata;
    logic [15:0] a, b, got1;
    wire  [1:0]  sck, sdi, ss_n;
    int          err_total, samples_checked, seed, k;

    spi_status_idle_control DUT (
        .clock_i(clock_i), .rstn_i(rstn_i), .hsel_i(hsel), .haddr_i(haddr),
        .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(3'h2), .hwdata_i(hwdata),
        .hready_i(hready), .hrdata_o(hrdata), .hreadyout_o(hready), .hresp_o(hresp),
        .cpu_idle_i(cpu_idle), .cpu_sleep_i(cpu_sleep), .serial_clock_pin_i(sck),
        .data_in_pin_i(sdi), .select_pin_i(ss_n), .data_out_pin_o(sdo),
        .data_out_pin_oe_o(sdo_oe), .pin_func_o(pin_func), .irq_o(irq)
    );
    spi_master_model m1 (.sck_o(sck[0]), .sdi_o(sdi[0]), .ss_n_o(ss_n[0]), .sdo_i(sdo[0]),
                         .got_o(got1));
    spi_master_model m2 (.sck_o(sck[1]), .sdi_o(sdi[1]), .ss_n_o(ss_n[1]), .sdo_i(sdo[1]),
                         .got_o());

    initial begin
        clock_i = 1'b0;
        forever #25 clock_i = ~clock_i;
    end

    function automatic logic [15:0] stat(input logic en, sidl, ovf, full);
        return {en, 1'b0, sidl, 6'h00, ovf, 5'h00, full};
    endfunction

    // 8-bit mode leaves the upper byte of the buffer at zero
    function automatic logic [15:0] exp_rx(input logic [15:0] d, input logic m16);
        return m16 ? d : {8'h00, d[7:0]};
    endfunction

    task automatic test_done();
        if (err_total == 0 && samples_checked > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    task automatic check(input string nm, input logic [15:0] seen, input logic [15:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            err_total++;
            $display("wrong value %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    // one single transfer; entered and left right at a rising edge
    task automatic bus(input logic w, input logic [9:0] idx, input logic [15:0] d,
                       output logic [15:0] q);
        int n;
        int m;
        hsel   <= 1'b1;
        htrans <= 2'h2;
        hwrite <= w;
        haddr  <= {20'h00000, idx, 2'h0};
        n = 0;
        do begin @(posedge clock_i); n++; end while (hready !== 1'b1 && n < 40);
        htrans <= 2'h0;
        hwdata <= {16'h0000, d};
        m = 0;
        do begin @(posedge clock_i); m++; end while (hready !== 1'b1 && m < 40);
        q = hrdata[15:0];
        check("hresp", {15'h0000, hresp}, 16'h0000);
        if (n >= 40 || m >= 40) begin
            err_total++;
            test_done();
        end
    endtask

    task automatic wr(input logic [9:0] idx, input logic [15:0] d);
        logic [15:0] q;
        bus(1'b1, idx, d, q);
        // let the written value reach the outputs before a caller samples them
        @(posedge clock_i);
    endtask

    task automatic rdchk(input logic [9:0] idx, input logic [15:0] exp);
        logic [15:0] q;
        bus(1'b0, idx, 16'h0000, q);
        check($sformatf("reg %h", idx), q, exp);
    endtask

    task automatic send(input logic p, input logic [15:0] d, input int n);
        if (p) m2.xfer(d, n);
        else m1.xfer(d, n);
        repeat (2) @(posedge clock_i);
    endtask

    task automatic pins(input string nm, input logic seen, input logic exp);
        @(posedge clock_i);
        check(nm, {15'h0000, seen}, {15'h0000, exp});
    endtask

    initial begin
        #2000000;
        err_total++;
        test_done();
    end

    initial begin
        seed = 11;
        err_total = 0;
        samples_checked = 0;
        rstn_i = 1'b0;
        {hsel, hwrite, cpu_idle, cpu_sleep} = 4'h0;
        htrans = 2'h0;
        haddr = 32'h00000000;
        hwdata = 32'h00000000;
        repeat (16) @(posedge clock_i);
        rstn_i <= 1'b1;
        @(posedge clock_i);
        rdchk(IDX_STAT1, 16'h0000);
        rdchk(IDX_CON1, CON_RESET);
        rdchk(IDX_BUF2, BUF_RESET);
        rdchk(IDX_IRQ_STAT, {12'h000, IRQ_RESET});
        pins("pin_func", pin_func[0], 1'b0);
        wr(IDX_STAT1, 16'hFFFF);
        rdchk(IDX_STAT1, stat(1, 1, 1, 0));
        pins("pin_func", pin_func[0], 1'b1);
        pins("sdo_oe", sdo_oe[0], 1'b1);
        wr(IDX_STAT1, 16'h8000);
        rdchk(IDX_STAT1, stat(1, 0, 0, 0));
        wr(IDX_CON1, 16'h0100);
        wr(IDX_STAT2, 16'h8000);
        wr(IDX_CON2, 16'h0500);
        wr(IDX_IRQ_MASK, 16'h000F);
        for (k = 0; k < 6; k++) begin
            a = 16'($random(seed));
            p2 = k[0];
            send(p2, a, p2 ? 16 : 8);
            rdchk(p2 ? IDX_STAT2 : IDX_STAT1, stat(1, 0, 0, 1));
            pins("irq", irq, 1'b1);
            rdchk(p2 ? IDX_BUF2 : IDX_BUF1, exp_rx(a, p2));
            rdchk(p2 ? IDX_STAT2 : IDX_STAT1, stat(1, 0, 0, 0));
            wr(IDX_IRQ_STAT, 16'h000F);
            pins("irq", irq, 1'b0);
        end
        // overflow: second word lost, port deaf until the buffer is read and the overflow bit cleared
        a = 16'($random(seed));
        b = 16'($random(seed));
        send(0, a, 8);
        send(0, b, 8);
        rdchk(IDX_STAT1, stat(1, 0, 1, 1));
        send(0, ~a, 8);
        rdchk(IDX_BUF1, exp_rx(a, 0));
        rdchk(IDX_STAT1, stat(1, 0, 1, 0));
        wr(IDX_STAT1, 16'h8000);
        send(0, b, 8);
        wr(IDX_BUF1, a);
        rdchk(IDX_STAT1, stat(1, 0, 0, 0));
        // idle with and without idle-stop
        wr(IDX_STAT1, 16'hA000);
        cpu_idle <= 1'b1;
        send(0, a, 8);
        rdchk(IDX_STAT1, stat(1, 1, 0, 0));
        wr(IDX_STAT1, 16'h8000);
        send(0, a, 8);
        rdchk(IDX_STAT1, stat(1, 0, 0, 1));
        check("sdo", {8'h00, got1[7:0]}, {8'h00, a[7:0]});
        cpu_idle <= 1'b0;
        rdchk(IDX_BUF1, exp_rx(a, 0));
        // sleep in mid-word drops the partial word, keeps registers
        send(0, 16'h00F0, 4);
        cpu_sleep <= 1'b1;
        send(0, a, 8);
        rdchk(IDX_STAT1, stat(1, 0, 0, 0));
        rdchk(IDX_CON1, 16'h0100);
        cpu_sleep <= 1'b0;
        send(0, b, 8);
        rdchk(IDX_BUF1, exp_rx(b, 0));
        // masked interrupt, unmapped place, disable
        wr(IDX_IRQ_STAT, 16'h000F);
        wr(IDX_IRQ_MASK, 16'h0000);
        send(1, a, 16);
        rdchk(IDX_IRQ_STAT, 16'h0004);
        pins("irq", irq, 1'b0);
        rdchk(10'h230, 16'h0000);
        wr(IDX_STAT1, 16'h0000);
        pins("pin_func", pin_func[0], 1'b0);
        pins("sdo_oe", sdo_oe[0], 1'b0);
        test_done();
    end
endmodule // spi_status_idle_control_tb
